// ==== hw/ats_pkg.sv ====
// Package with register map, field positions and bus carriers of the asynchronous timer block.
package ats_pkg;

  // ----------------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ----------------------------------------------------------------------
  localparam logic [9:0] IDX_FLAGS = 10'h037;
  localparam logic [9:0] IDX_ASYNC_STATUS = 10'h0B6;
  localparam logic [9:0] IDX_MASK = 10'h070;
  localparam logic [9:0] IDX_GEN_CTRL = 10'h043;
  localparam logic [9:0] IDX_COUNTER = 10'h0B2;
  localparam logic [9:0] IDX_COMPARE_A = 10'h0B3;
  localparam logic [9:0] IDX_COMPARE_B = 10'h0B4;
  localparam logic [9:0] IDX_CONTROL_A = 10'h0B0;
  localparam logic [9:0] IDX_CONTROL_B = 10'h0B1;

  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int BIT_EXT_CLOCK_ENABLE = 6;
  localparam int BIT_ASYNC_CLOCK_SELECT = 5;
  localparam int BIT_COUNTER_BUSY = 4;
  localparam int BIT_TIMER_SYNC_MODE = 7;
  localparam int BIT_ASYNC_PRESCALER_RESET = 1;
  localparam int BIT_SYNC_PRESCALER_RESET = 0;
  localparam int BIT_COMPARE_B = 2;
  localparam int BIT_COMPARE_A = 1;
  localparam int BIT_OVERFLOW = 0;
  localparam int BIT_WGM2 = 3;

  // Busy flag order inside the five-bit busy vector.
  localparam int BUSY_COUNTER = 4;
  localparam int BUSY_COMPARE_A = 3;
  localparam int BUSY_COMPARE_B = 2;
  localparam int BUSY_CONTROL_A = 1;
  localparam int BUSY_CONTROL_B = 0;

  // Writable bits of the control registers; the rest read as zero.
  localparam logic [7:0] CONTROL_A_MASK = 8'hF3;
  localparam logic [7:0] CONTROL_B_MASK = 8'h0F;

  // ----------------------------------------------------------------------
  // Values after reset and fixed counts.
  // ----------------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [9:0] PRESCALER_RESET = 10'h000;

  // ----------------------------------------------------------------------
  // Carriers.
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ats_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ats_apb_rsp_t;

  // Bit 2 compare B, bit 1 compare A, bit 0 overflow.
  typedef logic [2:0] ats_irq_t;

endpackage : ats_pkg

// ==== hw/ats_sync2.sv ====
// Two-flop synchronizer with asynchronous active-low reset.
`timescale 1ns/100ps
module ats_sync2 (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Data.
  input wire logic d,
  output logic q
);

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic meta;
    logic stable;
  } ats_sync_state_t;

  ats_sync_state_t s_r;
  ats_sync_state_t s_nxt;

  // The first stage feeds only the second stage.
  always_comb begin
    s_nxt.meta = d;
    s_nxt.stable = s_r.meta;
  end

  // Both stages clear on reset.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.stable;

endmodule : ats_sync2

// ==== hw/ats_timer.sv ====
// Asynchronous timer with update handshake, flags, masks and prescaler reset control.
//
// Overview of operation
// [RQ1] Timer clocks from the system clock, or from the oscillator pin when selected.
// [RQ2] Changing the clock select may corrupt counter, compares and controls.
// [RQ3] Counter write in async mode sets busy; cleared when counter loads.
// [RQ4] Compare A write in async mode sets busy; cleared when loaded.
// [RQ5] Compare B write in async mode sets busy; cleared when loaded.
// [RQ6] Control A write in async mode sets busy; cleared when loaded.
// [RQ7] Control B write in async mode sets busy; cleared when loaded.
// [RQ8] Software must not write a register while its busy flag is set.
// [RQ9] Counter reads live value; compares and controls read their holding registers.
// [RQ10] Three enables gate flags with the global interrupt bit into requests.
// [RQ11] Compare B flag sets when counter matches compare B.
// [RQ12] Compare A flag sets when counter matches compare A.
// [RQ13] Overflow flag sets on overflow, or at bottom turn in PWM.
// [RQ14] Flags clear on vector execution or on write of one.
// [RQ15] Sync mode holds both prescaler resets; leaving it clears them.
// [RQ16] Async prescaler reset self-clears, waits in async mode, holds in sync mode.
// [RQ17] Shared prescaler reset self-clears unless sync mode is active.
// [RQ18] External clock enable selects input buffer; crystal runs only otherwise.
// [RQ19] Holding-register transfers cross by synchronized oscillator edges.
// [RQ20] Busy flags are read-only; writes to them are ignored.
//
// Our own choice: the APB slave port.
`timescale 1ns/100ps
module ats_timer (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Register bus.
  input wire ats_pkg::ats_apb_req_t apb_req,
  output ats_pkg::ats_apb_rsp_t apb_rsp,
  // Timer oscillator pin and global interrupt enable.
  input wire logic timer_osc_pin_one,
  input wire logic cpu_status_word_ie,
  // Interrupt vector executed, one bit per source.
  input wire ats_pkg::ats_irq_t vector_taken,
  // Interrupt requests, oscillator controls and shared prescaler reset.
  output ats_pkg::ats_irq_t irq_req,
  output logic osc_crystal_enable,
  output logic ext_clock_buffer_enable,
  output logic sync_prescaler_reset
);
  import ats_pkg::*;

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] counter_value;
    logic [7:0] compare_value_a;
    logic [7:0] compare_value_b;
    logic [7:0] timer_control_a;
    logic [7:0] timer_control_b;
    logic [7:0] hold_counter;
    logic [7:0] hold_compare_a;
    logic [7:0] hold_compare_b;
    logic [7:0] hold_control_a;
    logic [7:0] hold_control_b;
    logic [4:0] update_busy;
    logic async_clock_select;
    logic external_clock_enable;
    logic [2:0] irq_enable;
    logic [2:0] irq_flags;
    logic timer_sync_mode;
    logic async_prescaler_reset;
    logic sync_prescaler_reset;
    logic [9:0] prescaler;
    logic count_down;
    logic osc_last;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    ats_irq_t irq_req;
    logic osc_crystal_enable;
    logic ext_clock_buffer_enable;
  } ats_state_t;

  ats_state_t s_r;
  ats_state_t s_nxt;
  logic rstn_sync;
  logic osc_sync;

  // ----------------------------------------------------------------------
  // Functions.
  // ----------------------------------------------------------------------

  // True when the byte address selects the register of the given index.
  function automatic logic addr_hit(input logic [11:0] addr, input logic [9:0] idx);
    addr_hit = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
  endfunction : addr_hit

  // True when the prescaler value gives a count step for the clock select code.
  function automatic logic prescale_step(input logic [2:0] cs, input logic [9:0] ps);
    unique case (cs)
      3'h0: prescale_step = 1'b0;
      3'h1: prescale_step = 1'b1;
      3'h2: prescale_step = &ps[2:0];
      3'h3: prescale_step = &ps[4:0];
      3'h4: prescale_step = &ps[5:0];
      3'h5: prescale_step = &ps[6:0];
      3'h6: prescale_step = &ps[7:0];
      3'h7: prescale_step = &ps[9:0];
    endcase
  endfunction : prescale_step

  // ----------------------------------------------------------------------
  // Reset release and pin synchronization.
  // ----------------------------------------------------------------------
  ats_sync2 u_reset_sync (
    .clk(clk),
    .rstn(rstn),
    .d(1'b1),
    .q(rstn_sync)
  );

  ats_sync2 u_osc_sync (
    .clk(clk),
    .rstn(rstn_sync),
    .d(timer_osc_pin_one),
    .q(osc_sync)
  );

  // ----------------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------------
  always_comb begin
    logic src_tick;
    logic count_tick;
    logic setup;
    logic wr;
    logic [7:0] wd;
    logic [7:0] top;
    logic [2:0] mode;
    logic [2:0] flag_set;
    logic [2:0] flag_clr;
    logic counter_loaded;
    logic phase_correct;
    logic mapped;
    logic [7:0] rd;
    src_tick = 1'b0;
    count_tick = 1'b0;
    setup = 1'b0;
    wr = 1'b0;
    wd = RESET_BYTE;
    top = COUNT_MAX;
    mode = 3'h0;
    flag_set = 3'h0;
    flag_clr = 3'h0;
    counter_loaded = 1'b0;
    phase_correct = 1'b0;
    mapped = 1'b0;
    rd = RESET_BYTE;
    s_nxt = s_r;

    // Timer clock source: every system clock, or each rising oscillator edge.
    s_nxt.osc_last = osc_sync;
    src_tick = s_r.async_clock_select ? (osc_sync && !s_r.osc_last) : 1'b1; // [RQ1]

    // Oscillator pin drivers follow the clock source bits.
    s_nxt.osc_crystal_enable = s_r.async_clock_select && !s_r.external_clock_enable; // [RQ18]
    s_nxt.ext_clock_buffer_enable = s_r.async_clock_select && s_r.external_clock_enable; // [RQ18]

    // Holding registers move across on the synchronized oscillator edge only.
    if (s_r.async_clock_select && src_tick) begin // [RQ19]
      if (s_r.update_busy[BUSY_COUNTER]) begin
        s_nxt.counter_value = s_r.hold_counter; // [RQ3]
        s_nxt.update_busy[BUSY_COUNTER] = 1'b0; // [RQ3]
        counter_loaded = 1'b1;
      end
      if (s_r.update_busy[BUSY_COMPARE_A]) begin
        s_nxt.compare_value_a = s_r.hold_compare_a; // [RQ4]
        s_nxt.update_busy[BUSY_COMPARE_A] = 1'b0; // [RQ4]
      end
      if (s_r.update_busy[BUSY_COMPARE_B]) begin
        s_nxt.compare_value_b = s_r.hold_compare_b; // [RQ5]
        s_nxt.update_busy[BUSY_COMPARE_B] = 1'b0; // [RQ5]
      end
      if (s_r.update_busy[BUSY_CONTROL_A]) begin
        s_nxt.timer_control_a = s_r.hold_control_a; // [RQ6]
        s_nxt.update_busy[BUSY_CONTROL_A] = 1'b0; // [RQ6]
      end
      if (s_r.update_busy[BUSY_CONTROL_B]) begin
        s_nxt.timer_control_b = s_r.hold_control_b; // [RQ7]
        s_nxt.update_busy[BUSY_CONTROL_B] = 1'b0; // [RQ7]
      end
    end

    // Prescaler runs on the source clock and is held while its reset bit is set.
    if (s_r.async_prescaler_reset) begin
      s_nxt.prescaler = PRESCALER_RESET; // [RQ16]
    end else if (src_tick) begin
      s_nxt.prescaler = s_r.prescaler + 10'h001;
      count_tick = prescale_step(s_r.timer_control_b[2:0], s_r.prescaler);
    end

    // Counting sequence; a counter load blocks the step and the match of that tick.
    mode = {s_r.timer_control_b[BIT_WGM2], s_r.timer_control_a[1:0]};
    phase_correct = (mode == 3'h1) || (mode == 3'h5);
    top = (s_r.timer_control_b[BIT_WGM2] || (mode == 3'h2)) ? s_r.compare_value_a : COUNT_MAX;
    if (count_tick && !counter_loaded) begin
      flag_set[BIT_COMPARE_B] = (s_r.counter_value == s_r.compare_value_b); // [RQ11]
      flag_set[BIT_COMPARE_A] = (s_r.counter_value == s_r.compare_value_a); // [RQ12]
      if (phase_correct) begin
        if (s_r.count_down) begin
          if (s_r.counter_value == COUNT_BOTTOM) begin
            s_nxt.count_down = 1'b0;
            s_nxt.counter_value = s_r.counter_value + 8'h01;
            flag_set[BIT_OVERFLOW] = 1'b1; // [RQ13]
          end else begin
            s_nxt.counter_value = s_r.counter_value - 8'h01;
          end
        end else if (s_r.counter_value == top) begin
          s_nxt.count_down = 1'b1;
          s_nxt.counter_value = s_r.counter_value - 8'h01;
        end else begin
          s_nxt.counter_value = s_r.counter_value + 8'h01;
        end
      end else begin
        s_nxt.counter_value = (s_r.counter_value == top) ? COUNT_BOTTOM
                                                         : s_r.counter_value + 8'h01;
        flag_set[BIT_OVERFLOW] = (s_r.counter_value == COUNT_MAX) ||
                                 ((mode == 3'h7) && (s_r.counter_value == top)); // [RQ13]
      end
    end

    // Prescaler reset bits clear themselves unless sync mode holds them.
    if (!s_r.timer_sync_mode) begin
      s_nxt.sync_prescaler_reset = 1'b0; // [RQ17]
      if (!s_r.async_clock_select || src_tick) begin
        s_nxt.async_prescaler_reset = 1'b0; // [RQ16]
      end
    end

    // Register bus: answer is prepared in the setup cycle, writes land in the access cycle.
    setup = apb_req.psel && !apb_req.penable;
    wr = apb_req.psel && apb_req.penable && apb_req.pwrite && s_r.pready;
    wd = apb_req.pwdata[7:0];
    mapped = addr_hit(apb_req.paddr, IDX_FLAGS) || addr_hit(apb_req.paddr, IDX_ASYNC_STATUS) ||
             addr_hit(apb_req.paddr, IDX_MASK) || addr_hit(apb_req.paddr, IDX_GEN_CTRL) ||
             addr_hit(apb_req.paddr, IDX_COUNTER) || addr_hit(apb_req.paddr, IDX_COMPARE_A) ||
             addr_hit(apb_req.paddr, IDX_COMPARE_B) || addr_hit(apb_req.paddr, IDX_CONTROL_A) ||
             addr_hit(apb_req.paddr, IDX_CONTROL_B);
    if (addr_hit(apb_req.paddr, IDX_FLAGS)) begin
      rd = {5'h00, s_r.irq_flags};
    end else if (addr_hit(apb_req.paddr, IDX_ASYNC_STATUS)) begin
      rd = {1'b0, s_r.external_clock_enable, s_r.async_clock_select, s_r.update_busy};
    end else if (addr_hit(apb_req.paddr, IDX_MASK)) begin
      rd = {5'h00, s_r.irq_enable};
    end else if (addr_hit(apb_req.paddr, IDX_GEN_CTRL)) begin
      rd = {s_r.timer_sync_mode, 5'h00, s_r.async_prescaler_reset, s_r.sync_prescaler_reset};
    end else if (addr_hit(apb_req.paddr, IDX_COUNTER)) begin
      rd = s_r.counter_value; // [RQ9]
    end else if (addr_hit(apb_req.paddr, IDX_COMPARE_A)) begin
      rd = s_r.hold_compare_a; // [RQ9]
    end else if (addr_hit(apb_req.paddr, IDX_COMPARE_B)) begin
      rd = s_r.hold_compare_b; // [RQ9]
    end else if (addr_hit(apb_req.paddr, IDX_CONTROL_A)) begin
      rd = s_r.hold_control_a; // [RQ9]
    end else if (addr_hit(apb_req.paddr, IDX_CONTROL_B)) begin
      rd = s_r.hold_control_b; // [RQ9]
    end
    s_nxt.pready = setup;
    s_nxt.pslverr = setup && !mapped;
    if (setup) begin
      s_nxt.prdata = {24'h000000, rd};
    end

    // Register writes; in async mode the holding copy waits for the transfer.
    if (wr) begin
      if (addr_hit(apb_req.paddr, IDX_FLAGS)) begin
        flag_clr = wd[2:0]; // [RQ14]
      end
      if (addr_hit(apb_req.paddr, IDX_MASK)) begin
        s_nxt.irq_enable = wd[2:0]; // [RQ10]
      end
      if (addr_hit(apb_req.paddr, IDX_ASYNC_STATUS)) begin
        // Busy positions are not stored.
        s_nxt.external_clock_enable = wd[BIT_EXT_CLOCK_ENABLE]; // [RQ20]
        s_nxt.async_clock_select = wd[BIT_ASYNC_CLOCK_SELECT]; // [RQ1]
        if (wd[BIT_ASYNC_CLOCK_SELECT] != s_r.async_clock_select) begin
          // Pending transfers are dropped when the clock source changes.
          s_nxt.update_busy = 5'h00; // [RQ2]
          s_nxt.count_down = 1'b0; // [RQ2]
        end
      end
      if (addr_hit(apb_req.paddr, IDX_GEN_CTRL)) begin
        s_nxt.timer_sync_mode = wd[BIT_TIMER_SYNC_MODE]; // [RQ15]
        if (wd[BIT_TIMER_SYNC_MODE]) begin
          s_nxt.async_prescaler_reset = wd[BIT_ASYNC_PRESCALER_RESET]; // [RQ15]
          s_nxt.sync_prescaler_reset = wd[BIT_SYNC_PRESCALER_RESET]; // [RQ15]
        end else if (s_r.timer_sync_mode) begin
          s_nxt.async_prescaler_reset = 1'b0; // [RQ15]
          s_nxt.sync_prescaler_reset = 1'b0; // [RQ15]
        end else begin
          s_nxt.async_prescaler_reset = wd[BIT_ASYNC_PRESCALER_RESET]; // [RQ16]
          s_nxt.sync_prescaler_reset = wd[BIT_SYNC_PRESCALER_RESET]; // [RQ17]
        end
      end
      if (addr_hit(apb_req.paddr, IDX_COUNTER)) begin
        s_nxt.hold_counter = wd;
        if (s_r.async_clock_select) begin
          s_nxt.update_busy[BUSY_COUNTER] = 1'b1; // [RQ3]
          // The live count keeps stepping until the holding copy moves across.
        end else begin
          s_nxt.counter_value = wd;
        end
      end
      if (addr_hit(apb_req.paddr, IDX_COMPARE_A)) begin
        s_nxt.hold_compare_a = wd;
        if (s_r.async_clock_select) begin
          s_nxt.update_busy[BUSY_COMPARE_A] = 1'b1; // [RQ4]
          s_nxt.compare_value_a = s_r.compare_value_a;
        end else begin
          s_nxt.compare_value_a = wd;
        end
      end
      if (addr_hit(apb_req.paddr, IDX_COMPARE_B)) begin
        s_nxt.hold_compare_b = wd;
        if (s_r.async_clock_select) begin
          s_nxt.update_busy[BUSY_COMPARE_B] = 1'b1; // [RQ5]
          s_nxt.compare_value_b = s_r.compare_value_b;
        end else begin
          s_nxt.compare_value_b = wd;
        end
      end
      if (addr_hit(apb_req.paddr, IDX_CONTROL_A)) begin
        s_nxt.hold_control_a = wd & CONTROL_A_MASK;
        if (s_r.async_clock_select) begin
          s_nxt.update_busy[BUSY_CONTROL_A] = 1'b1; // [RQ6]
          s_nxt.timer_control_a = s_r.timer_control_a;
        end else begin
          s_nxt.timer_control_a = wd & CONTROL_A_MASK;
        end
      end
      if (addr_hit(apb_req.paddr, IDX_CONTROL_B)) begin
        s_nxt.hold_control_b = wd & CONTROL_B_MASK;
        if (s_r.async_clock_select) begin
          s_nxt.update_busy[BUSY_CONTROL_B] = 1'b1; // [RQ7]
          s_nxt.timer_control_b = s_r.timer_control_b;
        end else begin
          s_nxt.timer_control_b = wd & CONTROL_B_MASK;
        end
      end
    end

    // Flags: a set in the same cycle as a clear wins.
    flag_clr = flag_clr | vector_taken; // [RQ14]
    s_nxt.irq_flags = (s_r.irq_flags & ~flag_clr) | flag_set; // [RQ14]

    // Requests need enable, global interrupt bit and flag.
    s_nxt.irq_req = s_r.irq_flags & s_r.irq_enable & {3{cpu_status_word_ie}}; // [RQ10]
  end

  // ----------------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn_sync) begin
    if (!rstn_sync) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign apb_rsp.prdata = s_r.prdata;
  assign apb_rsp.pready = s_r.pready;
  assign apb_rsp.pslverr = s_r.pslverr;
  assign irq_req = s_r.irq_req;
  assign osc_crystal_enable = s_r.osc_crystal_enable;
  assign ext_clock_buffer_enable = s_r.ext_clock_buffer_enable;
  assign sync_prescaler_reset = s_r.sync_prescaler_reset;

endmodule : ats_timer

// ==== sim/ats_timer_assertions.sv ====
// Checker of bus handshake, oscillator selection, interrupt and prescaler pins.
`timescale 1ns/100ps
module ats_timer_chk (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Register bus.
  input wire ats_pkg::ats_apb_req_t apb_req,
  input wire ats_pkg::ats_apb_rsp_t apb_rsp,
  // Pins.
  input wire logic timer_osc_pin_one,
  input wire logic cpu_status_word_ie,
  input wire ats_pkg::ats_irq_t vector_taken,
  input wire ats_pkg::ats_irq_t irq_req,
  input wire logic osc_crystal_enable,
  input wire logic ext_clock_buffer_enable,
  input wire logic sync_prescaler_reset
);
  import ats_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------------
  // Bus phases.
  // ----------------------------------------------------------------------
  sequence setup_s;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence wr_s(logic [9:0] ix);
    apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite &&
      apb_req.paddr == {ix, 2'b00};
  endsequence
  // ----------------------------------------------------------------------
  // Properties.
  // ----------------------------------------------------------------------
  AST_READY_NEXT: assert property (setup_s |=> apb_rsp.pready)
    else $error("pready missing after setup");
  AST_READY_CAUSE: assert property (apb_rsp.pready |-> apb_req.penable && $past(apb_req.psel))
    else $error("pready without access phase");
  AST_READY_PULSE: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready longer than one cycle");
  AST_ERR_READY: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("pslverr without pready");
  AST_RDATA_UPPER: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  AST_IRQ_IE: assert property (irq_req != 3'h0 |-> $past(cpu_status_word_ie))
    else $error("interrupt request without global enable");
  AST_XTAL_ON: assert property (wr_s(IDX_ASYNC_STATUS) ##0 apb_req.pwdata[6:5] == 2'b01
    |-> ##[1:2] osc_crystal_enable && !ext_clock_buffer_enable)
    else $error("crystal not enabled");
  AST_EXT_BUF: assert property (wr_s(IDX_ASYNC_STATUS) ##0 apb_req.pwdata[6:5] == 2'b11
    |-> ##[1:2] ext_clock_buffer_enable && !osc_crystal_enable)
    else $error("external buffer not enabled");
  AST_OSC_EXCL: assert property (osc_crystal_enable |-> !ext_clock_buffer_enable)
    else $error("crystal and external buffer both on");
  AST_SPR_PULSE: assert property (wr_s(IDX_GEN_CTRL) ##0 apb_req.pwdata[7:0] == 8'h01
    |-> ##[1:2] sync_prescaler_reset ##1 !sync_prescaler_reset)
    else $error("shared prescaler reset did not self clear");
  AST_SPR_HOLD: assert property (wr_s(IDX_GEN_CTRL) ##0 apb_req.pwdata[7:0] == 8'h83
    |-> ##2 sync_prescaler_reset [*4])
    else $error("shared prescaler reset not held");
endmodule : ats_timer_chk

bind ats_timer ats_timer_chk u_chk (.clk(clk), .rstn(rstn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .timer_osc_pin_one(timer_osc_pin_one),
  .cpu_status_word_ie(cpu_status_word_ie), .vector_taken(vector_taken), .irq_req(irq_req),
  .osc_crystal_enable(osc_crystal_enable), .ext_clock_buffer_enable(ext_clock_buffer_enable),
  .sync_prescaler_reset(sync_prescaler_reset));

// ==== sim/async_timer_sync_and_flags_tb.sv ====
// Self-checking bench of the asynchronous timer block.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module async_timer_sync_and_flags_tb;
  import ats_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  ats_apb_req_t req = '0;
  ats_apb_rsp_t rsp;
  logic pin = 1'b0;
  logic ie = 1'b0;
  ats_irq_t vec = '0;
  ats_irq_t irq;
  logic xtal;
  logic extb;
  logic spr;
  int errors = 0;
  int check_count = 0;
  int seed = 32'h8208;
  logic [32:0] expq[$];
  logic [32:0] head;
  logic [9:0] idx[9] = '{IDX_FLAGS, IDX_ASYNC_STATUS, IDX_MASK, IDX_GEN_CTRL, IDX_COUNTER,
    IDX_COMPARE_A, IDX_COMPARE_B, IDX_CONTROL_A, IDX_CONTROL_B};
  logic [7:0] msk[5] = '{8'hFF, 8'hFF, 8'hFF, CONTROL_A_MASK, CONTROL_B_MASK};
  logic [7:0] val[5];
  // Clock of 4 ns period.
  always #2 clk = ~clk;
  ats_timer dut (.clk(clk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp), .timer_osc_pin_one(pin),
    .cpu_status_word_ie(ie), .vector_taken(vec), .irq_req(irq), .osc_crystal_enable(xtal),
    .ext_clock_buffer_enable(extb), .sync_prescaler_reset(spr));
  // ----------------------------------------------------------------------
  // Report, bus tasks and read monitor.
  // ----------------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // One bus transfer; the request stands until pready is sampled high.
  task automatic xfer(input logic wr, input logic [9:0] ix, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {ix, 2'b00}, pwdata: {24'h0, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (rsp.pready !== 1'b1) begin
      errors++;
      summarize();
    end
  endtask : xfer
  // A read notes the expected error bit and data before it starts.
  task automatic rd(input logic [9:0] ix, input logic [32:0] e);
    expq.push_back(e);
    xfer(1'b0, ix, 8'h00);
  endtask : rd
  // Compares each completed read with the oldest note.
  always @(posedge clk) begin
    if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite) begin
      if (expq.size() == 0) begin
        errors++;
        $display("mismatch read exp none got %h", {rsp.pslverr, rsp.prdata});
      end else begin
        head = expq.pop_front();
        `CHK("read", head, {rsp.pslverr, rsp.prdata})
      end
    end
  end
  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    cyc(4);
    // Reset values, then an unmapped word.
    foreach (idx[i]) rd(idx[i], 33'h0);
    rd(10'h3FF, {1'b1, 32'h0});
    // Busy bits ignore writes; external buffer versus crystal.
    xfer(1'b1, IDX_ASYNC_STATUS, 8'hFF);
    rd(IDX_ASYNC_STATUS, 33'h60);
    `CHK("ext_buf", 2'b01, {xtal, extb})
    xfer(1'b1, IDX_ASYNC_STATUS, 8'h20);
    cyc(2);
    `CHK("xtal", 2'b10, {xtal, extb})
    // Asynchronous writes wait in holding copies until an oscillator edge.
    foreach (val[i]) val[i] = 8'($random(seed));
    val[4] = 8'h00;
    foreach (val[i]) xfer(1'b1, idx[i+4], val[i]);
    rd(IDX_ASYNC_STATUS, 33'h3F);
    rd(IDX_COUNTER, 33'h0);
    for (int i = 1; i < 5; i++) rd(idx[i+4], {25'h0, val[i] & msk[i]});
    pin <= 1'b1;
    cyc(8);
    pin <= 1'b0;
    cyc(8);
    rd(IDX_ASYNC_STATUS, 33'h20);
    rd(IDX_COUNTER, {25'h0, val[0]});
    // A free count in synchronous mode raises all three flags.
    xfer(1'b1, IDX_ASYNC_STATUS, 8'h00);
    xfer(1'b1, IDX_CONTROL_A, 8'h00);
    xfer(1'b1, IDX_COMPARE_A, 8'h05);
    xfer(1'b1, IDX_COMPARE_B, 8'h10);
    xfer(1'b1, IDX_COUNTER, 8'h00);
    xfer(1'b1, IDX_CONTROL_B, 8'h01);
    cyc(300);
    xfer(1'b1, IDX_CONTROL_B, 8'h00);
    rd(IDX_FLAGS, 33'h07);
    // Requests, vector clear, write-one clear and the global enable.
    ie <= 1'b1;
    xfer(1'b1, IDX_MASK, 8'h07);
    rd(IDX_MASK, 33'h07);
    `CHK("irq", 3'b111, irq)
    vec <= 3'b001;
    cyc(1);
    vec <= 3'b000;
    cyc(3);
    `CHK("irq_vec", 3'b110, irq)
    xfer(1'b1, IDX_FLAGS, 8'h02);
    rd(IDX_FLAGS, 33'h04);
    ie <= 1'b0;
    cyc(3);
    `CHK("irq_ie", 3'b000, irq)
    // Phase correct count: overflow only at the bottom turn, not at the top.
    xfer(1'b1, IDX_FLAGS, 8'h07);
    xfer(1'b1, IDX_CONTROL_A, 8'h01);
    xfer(1'b1, IDX_COUNTER, 8'h00);
    xfer(1'b1, IDX_CONTROL_B, 8'h01);
    cyc(300);
    rd(IDX_FLAGS, 33'h06);
    cyc(250);
    xfer(1'b1, IDX_CONTROL_B, 8'h00);
    rd(IDX_FLAGS, 33'h07);
    // Synchronization mode holds both prescaler resets until it is left.
    xfer(1'b1, IDX_GEN_CTRL, 8'h83);
    rd(IDX_GEN_CTRL, 33'h83);
    `CHK("spr_hold", 1'b1, spr)
    xfer(1'b1, IDX_GEN_CTRL, 8'h03);
    rd(IDX_GEN_CTRL, 33'h00);
    xfer(1'b1, IDX_GEN_CTRL, 8'h01);
    rd(IDX_GEN_CTRL, 33'h00);
    `CHK("spr_clear", 1'b0, spr)
    summarize();
  end
endmodule : async_timer_sync_and_flags_tb
